// *** rtl/amc_top.sv ***
// Purpose: Mode control and output formatting for a dual-channel converter
// Assumes: Serial pins are asynchronous and are sampled by sys_clk
// Notes:   Pin changes count once synchroniser stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module amc_top
	import amc_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  rst_b,
	input  wire logic  programming_mode_select,
	input  wire logic  cs_b,
	input  wire logic  sck,
	input  wire logic  sdi,
	input  wire logic  sdo_in,
	output logic       sdo_out,
	output logic       sdo_oe_b,
	input  wire logic  sample_en,
	input  wire amc_smp_s ch1_in,
	input  wire amc_smp_s ch2_in,
	output amc_smp_s   ch1_out,
	output amc_smp_s   ch2_out,
	output logic       data_output_clock,
	output logic       out_oe_b,
	output logic       dcs_on,
	output logic [1:0] out_mode,
	output logic       lvds_term,
	output logic [2:0] lvds_cur,
	output logic [1:0] clk_phase,
	output logic       clk_inv,
	output logic       ch1_nap,
	output logic       ch2_nap,
	output logic       sleep
);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	logic [4:0]   s1_r;
	logic [4:0]   s2_r;
	logic [4:0]   s3_r;
	logic [4:0]   flt_r;
	logic [4:0]   prev_r;
	amc_sp_e      sp_r;
	logic [4:0]   cnt_r;
	logic [15:0]  sh_r;
	logic [7:0]   rd_r;
	logic         rd_act_r;
	logic         sdo_drv_r;
	logic [7:0]   regs_r [1:NREG];
	logic         swrst_r;
	logic         phase_r;
	logic         par;
	logic         sck_rise;
	logic         sck_fall;
	logic         cs_fall;
	logic         cs_rise;
	logic         commit;
	logic [1:0]   pwr_code;
	amc_fmt_cfg_s fcfg;
	logic [31:0]  regs_flat;

	// Register read for the serial port; reset register reads zero
	function automatic logic [7:0] reg_read(logic [6:0] a);
		logic [7:0] v;
		v = REG_RST;
		if (a >= ADDR_PWR && a <= ADDR_FMT)
			v = regs_r[a[2:0]];
		return v;
	endfunction : reg_read

	// Three-stage synchroniser; the filtered level moves only on agreement
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_r   <= PIN_RST;
			s2_r   <= PIN_RST;
			s3_r   <= PIN_RST;
			flt_r  <= PIN_RST;
			prev_r <= PIN_RST;
		end
		else
		begin
			s1_r   <= {sdo_in, sdi, sck, cs_b, programming_mode_select};
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			flt_r  <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
			prev_r <= flt_r;
		end
	end

	// Edge decode on the filtered pins
	assign par      = flt_r[PIN_MODE];
	assign sck_rise = flt_r[PIN_SCK] & ~prev_r[PIN_SCK];
	assign sck_fall = ~flt_r[PIN_SCK] & prev_r[PIN_SCK];
	assign cs_fall  = ~flt_r[PIN_CS] & prev_r[PIN_CS];
	assign cs_rise  = flt_r[PIN_CS] & ~prev_r[PIN_CS];

	// A write lands only on a complete word closed by chip select
	assign commit = !par && sp_r == SP_SHIFT && cs_rise
		&& cnt_r == WORD_BITS && !sh_r[15];

	// Frame state: chip select opens and closes a transfer
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			sp_r <= SP_IDLE;
		else if (par)
			sp_r <= SP_IDLE;
		else if (cs_fall)
			sp_r <= SP_SHIFT;
		else if (cs_rise)
			sp_r <= SP_IDLE;
	end

	// Input shift; edges past the sixteenth are dropped
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= '0;
			sh_r  <= '0;
		end
		else if (cs_fall)
		begin
			cnt_r <= '0;
			sh_r  <= '0;
		end
		else if (!par && sp_r == SP_SHIFT && sck_rise && cnt_r < WORD_BITS)
		begin
			sh_r  <= {sh_r[14:0], flt_r[PIN_SDI]};
			cnt_r <= cnt_r + 5'h01;
		end
	end

	// Read-back: header complete loads the addressed byte, then shift
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_r     <= '0;
			rd_act_r <= 1'b0;
		end
		else if (cs_fall || par)
		begin
			rd_r     <= '0;
			rd_act_r <= 1'b0;
		end
		else if (sp_r == SP_SHIFT && sck_rise && cnt_r == HDR_LAST)
		begin
			rd_act_r <= sh_r[6];
			rd_r     <= reg_read({sh_r[5:0], flt_r[PIN_SDI]});
		end
		else if (sp_r == SP_SHIFT && sck_fall
			&& cnt_r >= SHIFT_FIRST && cnt_r < WORD_BITS)
			rd_r <= {rd_r[6:0], 1'b0};
	end

	// Open-drain driver: pull low for zero bits only, never in parallel mode
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			sdo_drv_r <= 1'b0;
		else
			sdo_drv_r <= !par && sp_r == SP_SHIFT && rd_act_r
				&& cnt_r >= RD_FIRST && !rd_r[7];
	end

	assign sdo_out  = 1'b0;
	assign sdo_oe_b = ~sdo_drv_r;

	// Mode registers; the reset bit itself is never stored
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 1; i <= NREG; i++)
				regs_r[i] <= REG_RST;
		end
		else if (commit && sh_r[14:8] == ADDR_RESET)
		begin
			if (sh_r[RST_BIT])
				for (int i = 1; i <= NREG; i++)
					regs_r[i] <= REG_RST;
		end
		else if (commit && sh_r[14:8] >= ADDR_PWR && sh_r[14:8] <= ADDR_FMT)
			regs_r[sh_r[10:8]] <= sh_r[7:0];
	end

	// Software reset briefly puts the converter to sleep
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			swrst_r <= 1'b0;
		else
			swrst_r <= commit && sh_r[14:8] == ADDR_RESET && sh_r[RST_BIT];
	end

	assign regs_flat = {regs_r[4], regs_r[3], regs_r[2], regs_r[1]};

	// Power code from pins or register
	assign pwr_code = par ? {flt_r[PIN_SDI], flt_r[PIN_SDO]}
		: regs_r[1][1:0];

	// Power controls; channel 1 only naps together with channel 2
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ch1_nap <= 1'b0;
			ch2_nap <= 1'b0;
			sleep   <= 1'b0;
		end
		else
		begin
			ch2_nap <= pwr_code == PWR_NAP2 || pwr_code == PWR_NAPBOTH;
			ch1_nap <= pwr_code == PWR_NAPBOTH;
			sleep   <= pwr_code == PWR_SLEEP || swrst_r;
		end
	end

	// Clock and output-driver controls; parallel mode takes stabilizer from chip select, output mode from sck, the rest fixed defaults
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dcs_on    <= 1'b0;
			out_mode  <= OM_CMOS;
			lvds_term <= 1'b0;
			lvds_cur  <= CUR_3P5MA;
			clk_phase <= '0;
			clk_inv   <= 1'b0;
			out_oe_b  <= 1'b0;
		end
		else if (par)
		begin
			dcs_on    <= flt_r[PIN_CS];
			out_mode  <= flt_r[PIN_SCK] ? OM_LVDS : OM_CMOS;
			lvds_term <= 1'b0;
			lvds_cur  <= CUR_3P5MA;
			clk_phase <= '0;
			clk_inv   <= 1'b0;
			out_oe_b  <= 1'b0;
		end
		else
		begin
			dcs_on    <= regs_r[2][TIM_DCS];
			out_mode  <= regs_r[3][OM_MODE_LSB +: 2];
			lvds_term <= regs_r[3][OM_TERM];
			lvds_cur  <= regs_r[3][OM_CUR_LSB +: 3];
			clk_phase <= regs_r[2][TIM_PH_LSB +: 2];
			clk_inv   <= regs_r[2][TIM_INV];
			out_oe_b  <= regs_r[3][OM_DIS];
		end
	end

	// Formatting options exist only in serial mode
	always_comb
	begin
		fcfg = '0;
		if (!par)
		begin
			fcfg.twos    = regs_r[4][FMT_TWOS];
			fcfg.rand_en = regs_r[4][FMT_RAND];
			fcfg.alt_pol = regs_r[4][FMT_ALT];
			fcfg.tp_sel  = amc_tp_e'(regs_r[4][FMT_TP_LSB +: 2]);
			fcfg.tp_en   = regs_r[4][FMT_TP_EN];
		end
	end

	// Sample phase drives alternating patterns and the output clock
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			phase_r <= 1'b0;
		else if (sample_en)
			phase_r <= ~phase_r;
	end

	// Output clock is not formatted, only toggled per sample
	assign data_output_clock = phase_r;

	amc_fmt u_fmt1 (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.smp_en  (sample_en),
		.phase   (phase_r),
		.cfg     (fcfg),
		.din     (ch1_in),
		.dout_r  (ch1_out)
	);

	amc_fmt u_fmt2 (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.smp_en  (sample_en),
		.phase   (phase_r),
		.cfg     (fcfg),
		.din     (ch2_in),
		.dout_r  (ch2_out)
	);

	a_nap_order: assert property (ch1_nap |-> ch2_nap)
		else $error("channel 1 napping alone");

	a_par_sleep: assert property (par && flt_r[PIN_SDI] && flt_r[PIN_SDO]
		|=> sleep)
		else $error("parallel sleep code ignored");

	a_par_dcs: assert property (par ##1 par |-> dcs_on == $past(flt_r[PIN_CS]))
		else $error("duty stabilizer not following chip select");

	a_par_lvds: assert property (par && flt_r[PIN_SCK]
		|=> out_mode == 2'h2 && !lvds_term && lvds_cur == 3'h0)
		else $error("parallel LVDS selection wrong");

	a_short_frame: assert property (sp_r == SP_SHIFT && cs_rise && cnt_r != 5'h10
		|=> $stable(regs_flat))
		else $error("short transfer changed a register");

	a_edge_limit: assert property (sck_rise && cnt_r == 5'h10 && !cs_fall
		|=> $stable(sh_r) && cnt_r == 5'h10)
		else $error("rising edge after sixteenth sampled");

	a_swrst_clear: assert property (commit && sh_r[14:8] == 7'h00 && sh_r[7]
		|=> regs_flat == 32'h0000_0000 ##1 sleep)
		else $error("software reset did not clear registers");

	a_sdo_quiet: assert property (par |=> sdo_oe_b)
		else $error("data out driven in parallel mode");

	a_out_off: assert property (!par && regs_r[3][3] |=> out_oe_b)
		else $error("outputs not disabled");

endmodule : amc_top
`default_nettype wire

// *** rtl/amc_pkg.sv ***
// Purpose: Shared constants and types for the ADC mode and output format block
// Assumes: 12-bit samples per channel, 16-bit serial configuration words
// Notes:   Register offsets are serial addresses; field positions are bit numbers
package amc_pkg;

	// Sample word and pattern constants
	localparam int          DW          = 12;
	localparam logic [11:0] ALT_MASK    = 12'hAAA;
	localparam logic [12:0] CHECK_A     = 13'h1555;
	localparam logic [12:0] CHECK_B     = 13'h0AAA;

	// Serial word layout
	localparam logic [4:0]  WORD_BITS   = 5'h10;
	localparam logic [4:0]  HDR_LAST    = 5'h07;
	localparam logic [4:0]  RD_FIRST    = 5'h08;
	localparam logic [4:0]  SHIFT_FIRST = 5'h09;

	// Register addresses
	localparam logic [6:0]  ADDR_RESET  = 7'h00;
	localparam logic [6:0]  ADDR_PWR    = 7'h01;
	localparam logic [6:0]  ADDR_TIMING = 7'h02;
	localparam logic [6:0]  ADDR_OMODE  = 7'h03;
	localparam logic [6:0]  ADDR_FMT    = 7'h04;
	localparam int          NREG        = 4;
	localparam logic [7:0]  REG_RST     = 8'h00;

	// Field positions
	localparam int          RST_BIT     = 7;
	localparam int          TIM_DCS     = 0;
	localparam int          TIM_PH_LSB  = 1;
	localparam int          TIM_INV     = 3;
	localparam int          OM_MODE_LSB = 0;
	localparam int          OM_TERM     = 2;
	localparam int          OM_DIS      = 3;
	localparam int          OM_CUR_LSB  = 4;
	localparam int          FMT_TWOS    = 0;
	localparam int          FMT_RAND    = 1;
	localparam int          FMT_ALT     = 2;
	localparam int          FMT_TP_LSB  = 3;
	localparam int          FMT_TP_EN   = 5;

	// Power-down codes
	localparam logic [1:0]  PWR_NORMAL  = 2'h0;
	localparam logic [1:0]  PWR_NAP2    = 2'h1;
	localparam logic [1:0]  PWR_NAPBOTH = 2'h2;
	localparam logic [1:0]  PWR_SLEEP   = 2'h3;

	// Output mode codes and default drive
	localparam logic [1:0]  OM_CMOS     = 2'h0;
	localparam logic [1:0]  OM_LVDS     = 2'h2;
	localparam logic [2:0]  CUR_3P5MA   = 3'h0;

	// Pin vector positions for the synchroniser
	localparam int          PIN_MODE    = 0;
	localparam int          PIN_CS      = 1;
	localparam int          PIN_SCK     = 2;
	localparam int          PIN_SDI     = 3;
	localparam int          PIN_SDO     = 4;
	localparam logic [4:0]  PIN_RST     = 5'h02;

	typedef enum logic [1:0] {TP_ONES, TP_ZEROS, TP_ALT, TP_CHECK} amc_tp_e;
	typedef enum logic {SP_IDLE, SP_SHIFT} amc_sp_e;

	typedef struct packed {
		logic        ovf;
		logic [11:0] data;
	} amc_smp_s;

	typedef struct packed {
		logic        tp_en;
		amc_tp_e     tp_sel;
		logic        alt_pol;
		logic        rand_en;
		logic        twos;
	} amc_fmt_cfg_s;

endpackage : amc_pkg

// *** rtl/amc_fmt.sv ***
// Purpose: Output formatter for one converter channel
// Assumes: smp_en marks one new sample per sample clock
// Notes:   Test patterns are applied last so nothing else can alter them
`timescale 1ns/1ns
`default_nettype none
module amc_fmt
	import amc_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire logic         smp_en,
	input  wire logic         phase,
	input  wire amc_fmt_cfg_s cfg,
	input  wire amc_smp_s     din,
	output amc_smp_s          dout_r
);

	// Coding, randomizer, polarity, then pattern override
	function automatic amc_smp_s fmt_word(amc_smp_s w, amc_fmt_cfg_s c, logic ph);
		amc_smp_s r;
		r = w;
		if (c.twos)
			r.data[11] = ~r.data[11];
		if (c.rand_en)
			r.data[11:1] = r.data[11:1] ^ {11{r.data[0]}};
		if (c.alt_pol)
			r.data = r.data ^ ALT_MASK;
		if (c.tp_en)
		begin
			unique case (c.tp_sel)
				TP_ONES:  r = '1;
				TP_ZEROS: r = '0;
				TP_ALT:   r = ph ? '1 : '0;
				TP_CHECK: r = ph ? CHECK_B : CHECK_A;
			endcase
		end
		return r;
	endfunction : fmt_word

	// Output word is held until the next sample
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
			dout_r <= '0;
		else if (smp_en)
			dout_r <= fmt_word(din, cfg, phase);
	end

	a_tp_ones: assert property (@(posedge sys_clk) disable iff (!rst_b)
		smp_en && cfg.tp_en && cfg.tp_sel == TP_ONES |=> dout_r == 13'h1FFF)
		else $error("test pattern ones not forced");

	a_alt_odd: assert property (@(posedge sys_clk) disable iff (!rst_b)
		smp_en && !cfg.tp_en && cfg.alt_pol && !cfg.rand_en && !cfg.twos
		|=> dout_r.data == ($past(din.data) ^ 12'hAAA) && dout_r.ovf == $past(din.ovf))
		else $error("odd bits not inverted");

endmodule : amc_fmt
`default_nettype wire

// *** tb/amc_host.sv ***
// Purpose: Host model driving the chip select, serial clock and data-in pins of the block
// Assumes: Pins change just after sys_clk rising edges
// Notes:   Serial clock idles low between frames; 80 ns period
`timescale 1ns/1ns
`default_nettype none
module amc_host (
	input  wire logic sys_clk,
	input  wire logic sdo_line,
	output logic      cs_b,
	output logic      sck,
	output logic      sdi
);
	// Idle levels: frame closed, clock still
	initial
	begin
		cs_b = 1'h1;
		sck  = 1'h0;
		sdi  = 1'h0;
	end

	// Static levels for parallel mode, where the pins are plain inputs
	task automatic hold_pins(input logic c, input logic k, input logic d);
		@(posedge sys_clk);
		cs_b <= c;
		sck  <= k;
		sdi  <= d;
	endtask : hold_pins

	// One framed word; bits past 16 keep sdi high so a miscount would show
	task automatic xfer(input logic [15:0] w, input int n_bits, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge sys_clk);
		cs_b <= 1'h0;
		repeat (4) @(posedge sys_clk);
		for (int i = 0; i < n_bits; i++)
		begin
			sdi <= (i < 16) ? w[15 - i] : 1'h1;
			repeat (4) @(posedge sys_clk);
			sck <= 1'h1;
			repeat (3) @(posedge sys_clk);
			// Sample late in the high phase: the pin synchroniser delays the device
			#1;
			if (i >= 8)
				rd = {rd[6:0], sdo_line};
			@(posedge sys_clk);
			sck <= 1'h0;
		end
		repeat (4) @(posedge sys_clk);
		cs_b <= 1'h1;
		repeat (12) @(posedge sys_clk);
	endtask : xfer
endmodule : amc_host
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the mode control and output format block
// Assumes: Host model drives the serial pins; pull-up on the data-out line
// Notes:   Outputs follow fixed latencies, so waits are fixed counts
`timescale 1ns/1ns
`default_nettype none
module tb
	import amc_pkg::*;
;
	logic       sys_clk                 = 1'h0;
	logic       rst_b                   = 1'h0;
	logic       programming_mode_select = 1'h0;
	logic       pin_drv                 = 1'h1;
	logic       sample_en               = 1'h0;
	amc_smp_s   ch1_in                  = '0;
	amc_smp_s   ch2_in                  = '0;
	amc_smp_s   ch1_out, ch2_out;
	logic       cs_b, sck, sdi, sdo_out, sdo_oe_b, data_output_clock, out_oe_b, dcs_on;
	logic       lvds_term, clk_inv, ch1_nap, ch2_nap, sleep;
	logic [1:0] out_mode, clk_phase;
	logic [2:0] lvds_cur;
	int         err_total               = 0;
	int         checks_done             = 0;
	// Pull-up unless the device pulls low; in parallel mode the bench drives it
	wire logic  sdo_in = sdo_oe_b ? pin_drv : sdo_out;

	always #5 sys_clk = ~sys_clk;

	amc_host h (.sys_clk, .sdo_line(sdo_in), .cs_b, .sck, .sdi);

	amc_top dut (.sys_clk, .rst_b, .programming_mode_select, .cs_b, .sck, .sdi, .sdo_in,
		.sdo_out, .sdo_oe_b, .sample_en, .ch1_in, .ch2_in, .ch1_out, .ch2_out,
		.data_output_clock, .out_oe_b, .dcs_on, .out_mode, .lvds_term, .lvds_cur,
		.clk_phase, .clk_inv, .ch1_nap, .ch2_nap, .sleep);

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask : chk

	// Expected formatting: offset to two's complement, randomizer, alternate polarity
	function automatic amc_smp_s fmt(input amc_smp_s s, input logic [2:0] f);
		amc_smp_s r;
		r = s;
		if (f[0])
			r.data[11] = ~r.data[11];
		if (f[1])
			r.data[11:1] = r.data[11:1] ^ {11{r.data[0]}};
		if (f[2])
			r.data = r.data ^ ALT_MASK;
		return r;
	endfunction : fmt

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		h.xfer({1'h0, a, d}, 16, x);
	endtask : wr

	// Data bits sent as ones: a read must not store them
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] x;
		h.xfer({1'h1, a, 8'hFF}, 16, x);
		chk("read back", e, x);
	endtask : rd_chk

	task automatic smp(input amc_smp_s v);
		logic k;
		k = data_output_clock;
		@(posedge sys_clk);
		ch1_in    <= v;
		ch2_in    <= ~v;
		sample_en <= 1'h1;
		@(posedge sys_clk);
		sample_en <= 1'h0;
		@(posedge sys_clk);
		#1;
		chk("output clock", k ? 1'h0 : 1'h1, data_output_clock);
	endtask : smp

	task automatic chk_pwr(input logic [1:0] c);
		chk("sleep", c == 2'h3, sleep);
		if (c != 2'h3)
			chk("nap", {c == 2'h2, c != 2'h0}, {ch1_nap, ch2_nap});
		chk("channel 1 nap alone", 1'h0, ch1_nap && !ch2_nap);
	endtask : chk_pwr

	task automatic t_reset();
		wr(ADDR_RESET, 8'h80);
		wr(ADDR_PWR, 8'h03);
		chk("sleep", 1'h1, sleep);
		wr(ADDR_RESET, 8'h80);
		chk("sleep", 1'h0, sleep);
		rd_chk(ADDR_PWR, 8'h00);
		rd_chk(ADDR_RESET, 8'h00);
	endtask : t_reset

	// Later writes must stick, so the reset bit has cleared itself
	task automatic t_pwr();
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_PWR, {6'h2D, c[1:0]});
			chk_pwr(c[1:0]);
			rd_chk(ADDR_PWR, {6'h2D, c[1:0]});
		end
	endtask : t_pwr

	task automatic t_refuse();
		logic [7:0] x;
		wr(ADDR_PWR, 8'h01);
		h.xfer({1'h0, ADDR_PWR, 8'h03}, 15, x);
		rd_chk(ADDR_PWR, 8'h01);
		h.xfer({1'h0, ADDR_PWR, 8'h02}, 20, x);
		rd_chk(ADDR_PWR, 8'h02);
		// A second read shows the first one left the register alone
		rd_chk(ADDR_PWR, 8'h02);
		wr(7'h05, 8'hFF);
		rd_chk(7'h05, 8'h00);
		wr(ADDR_PWR, 8'h00);
	endtask : t_refuse

	task automatic t_fmt();
		amc_smp_s s, a, b;
		s = 13'h16C5;
		// Host wake-up: 100 sample clocks after nap; 2ms sleep settling is analogue, not modelled
		repeat (100) smp(s);
		for (int i = 0; i < 8; i++)
		begin
			wr(ADDR_FMT, {5'h00, i[2:0]});
			smp(s);
			chk("ch1 format", fmt(s, i[2:0]), ch1_out);
			chk("ch2 format", fmt(~s, i[2:0]), ch2_out);
			// Receiver side: inverting the odd bits again must give back the raw sample
			if (i == 4)
				chk("restored", s, {ch1_out.ovf, ch1_out.data ^ ALT_MASK});
		end
		// Every other option on: the pattern must still come out untouched
		for (int p = 0; p < 4; p++)
		begin
			wr(ADDR_FMT, {2'h0, 1'h1, p[1:0], 3'h7});
			smp(s);
			a = ch1_out;
			chk("ch2 pattern", a, ch2_out);
			smp(~s);
			b = ch1_out;
			chk("pattern pair", (p < 2) ? 13'h0000 : 13'h1FFF, a ^ b);
			chk("pattern word", 1'h1, (p == 0) ? a == 13'h1FFF : (p == 1) ? a == 13'h0000 :
				(p == 2) ? (a == 13'h0000 || a == 13'h1FFF) : (a == CHECK_A || a == CHECK_B));
		end
		wr(ADDR_FMT, 8'h00);
	endtask : t_fmt

	task automatic t_oe();
		wr(ADDR_PWR, 8'h02);
		// Timing fields: stabilizer, phase 2, inverted clock
		wr(ADDR_TIMING, 8'h0D);
		chk("clock timing", 4'hD, {clk_inv, clk_phase, dcs_on});
		wr(ADDR_TIMING, 8'h00);
		chk("clock timing", 4'h0, {clk_inv, clk_phase, dcs_on});
		// Output mode fields: LVDS, termination on, current code 3, outputs on
		wr(ADDR_OMODE, 8'h36);
		chk("output mode reg", {3'h3, 1'h1, 2'h2}, {lvds_cur, lvds_term, out_mode});
		chk("output disable", 1'h0, out_oe_b);
		wr(ADDR_OMODE, 8'h08);
		chk("output disable", 1'h1, out_oe_b);
		wr(ADDR_OMODE, 8'h00);
		chk("output disable", 1'h0, out_oe_b);
		wr(ADDR_PWR, 8'h00);
	endtask : t_oe

	task automatic t_par();
		logic [3:0] v;
		@(posedge sys_clk);
		programming_mode_select <= 1'h1;
		repeat (6) @(posedge sys_clk);
		for (int i = 0; i < 16; i++)
		begin
			v = i[3:0];
			h.hold_pins(v[3], v[2], v[1]);
			pin_drv <= v[0];
			repeat (8) @(posedge sys_clk);
			#1;
			chk("stabilizer", v[3], dcs_on);
			chk("output mode", v[2] ? OM_LVDS : OM_CMOS, out_mode);
			if (v[2])
				chk("lvds drive", {1'h0, CUR_3P5MA}, {lvds_term, lvds_cur});
			chk_pwr(v[1:0]);
		end
		h.hold_pins(1'h1, 1'h0, 1'h0);
		pin_drv <= 1'h1;
		repeat (6) @(posedge sys_clk);
		programming_mode_select <= 1'h0;
		repeat (8) @(posedge sys_clk);
		rd_chk(ADDR_PWR, 8'h00);
	endtask : t_par

	initial
	begin
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'h1;
		repeat (6) @(posedge sys_clk);
		t_reset();
		t_pwr();
		t_refuse();
		t_fmt();
		t_oe();
		t_par();
		print_verdict();
	end

	// A hang counts as a mismatch and ends the run
	initial
	begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
